// ===== core/srsp_pkg.sv
// srsp_pkg: constants for the sensor result serial port
// assumes a 20 MHz core clock; host clocks arrive on pins
// Behaviour
// - select 001 i2c, 011 spi, 100 capacitance density
// - select 110 adds temperature density on low pin
// - lock 011 matches own address, else all
// - default address 28h with lock engaged
// - i2c works at 100 and 400 kHz
// - spi transmit only, up to 800 kHz
// - miso changes on falling edge unless phase set
// - spi clock idle level needs no setting
// - calibration bytes accepted over i2c only
// - snapshot packet at transfer start, refresh after end
// - 14-bit results sent msb first
// - read address with direction 1 is acknowledged
// - i2c bytes continue until master nack and stop
// - byte0 status and cap 13:8, byte1 cap 7:0
// - byte2 temp 13:6, byte3 temp 5:0 padded
// - spi packet is four bytes, same order
// - truncated spi reads are accepted
// - status 00 fresh, 01 stale, 10 command mode
// - diagnostic fault reports all ones 3fff
// - ready rises on new data, holds until read
// - write address acknowledged requests a conversion
package srsp_pkg;
    localparam logic [2:0]  SEL_I2C      = 3'h1;
    localparam logic [2:0]  SEL_SPI      = 3'h3;
    localparam logic [2:0]  SEL_CAPACITANCE_DENSITY_OUT    = 3'h4;
    localparam logic [2:0]  SEL_PDM_CT   = 3'h6;
    localparam logic [2:0]  LOCK_ON      = 3'h3;
    localparam logic [6:0]  ADDR_DEFAULT = 7'h28;
    localparam logic [1:0]  STAT_FRESH   = 2'h0;
    localparam logic [1:0]  STAT_STALE   = 2'h1;
    localparam logic [1:0]  STAT_CMD     = 2'h2;
    localparam int          RES_W        = 14;
    localparam logic [13:0] DIAG_VAL     = 14'h3fff;
    localparam int          PKT_W        = 32;
    localparam logic [3:0]  BYTE_BITS    = 4'h8;
    localparam int          FIFO_DEPTH   = 16;
    localparam int          FIFO_W       = 29;
    typedef enum logic [2:0] {I_IDLE, I_ADDR, I_ACKA, I_TX, I_MACK, I_RX, I_ACKW} srsp_i2c_e;
endpackage : srsp_pkg

// ===== core/srsp_port.sv
// srsp_port: result fifo and the i2c / spi result port with pin routing
// assumes host serial clocks far below clk/8; pins pass through two-stage synchronisers
`timescale 1ns/1ns
module srsp_fifo #(
    parameter int W = 29,
    parameter int D = 16
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic          push;
    logic          pop;

    assign in_ready  = cnt_r != (AW+1)'(D);
    assign out_valid = cnt_r != '0;
    assign out_data  = mem[rp_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : srsp_fifo

module srsp_port #(
    parameter int FIFO_D = srsp_pkg::FIFO_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        cfg_write,
    input  wire logic [2:0]  cfg_select,
    input  wire logic [2:0]  cfg_lock,
    input  wire logic [6:0]  bus_address_field,
    input  wire logic        cfg_spi_phase,
    input  wire logic        command_mode,
    input  wire logic        res_valid,
    output logic             res_ready,
    input  wire logic        res_diag,
    input  wire logic [13:0] res_cap,
    input  wire logic [13:0] res_temp,
    input  wire logic        alarm_low,
    input  wire logic        alarm_high,
    input  wire logic        capacitance_density_out,
    input  wire logic        temperature_density_out,
    output logic             pin_alarm_low_out,
    output logic             pin_alarm_high_out,
    output logic             pin_ready_out,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic        sclk_in,
    input  wire logic        ss_n_in,
    output logic             miso_out,
    output logic             miso_oe,
    output logic             conversion_request_command,
    output logic             result_read_command,
    output logic [7:0]       cmd_byte,
    output logic             cmd_valid
);
    function automatic logic uses_i2c(input logic [2:0] s);
        uses_i2c = (s == srsp_pkg::SEL_I2C) || (s == srsp_pkg::SEL_CAPACITANCE_DENSITY_OUT)
                   || (s == srsp_pkg::SEL_PDM_CT);
    endfunction : uses_i2c

    logic [2:0]  sel_r;
    logic [2:0]  lock_r;
    logic [6:0]  addr_r;
    logic        phase_r;
    logic [3:0]  sy1_r;
    logic [3:0]  sy2_r;
    logic [3:0]  sy3_r;
    logic        scl_s, sda_s, sclk_s, ss_s;
    logic        scl_rise, scl_fall, i2c_start, i2c_stop, ss_fall, ss_rise;
    logic        sclk_rise, sclk_fall, i2c_on, spi_on, busy;
    logic        f_valid, f_pop;
    logic [28:0] f_data;
    logic        diag_r, fresh_r;
    logic [13:0] cap_r, temp_r;
    logic [31:0] packet;
    srsp_pkg::srsp_i2c_e st_r;
    logic [3:0]  bit_r;
    logic [7:0]  rx_r;
    logic        rw_r, rd_i2c_r, acked_r;
    logic [31:0] tx_r;
    logic [31:0] spi_r;
    logic        seen_r;
    logic        rd_start;

    srsp_fifo #(.W(srsp_pkg::FIFO_W), .D(FIFO_D)) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (res_valid),
        .in_ready  (res_ready),
        .in_data   ({res_diag, res_cap, res_temp}),
        .out_valid (f_valid),
        .out_ready (~busy),
        .out_data  (f_data)
    );

    // configuration, reset to factory address with lock engaged
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_r   <= srsp_pkg::SEL_I2C;
            lock_r  <= srsp_pkg::LOCK_ON;
            addr_r  <= srsp_pkg::ADDR_DEFAULT;
            phase_r <= 1'b0;
        end else if (cfg_write) begin
            sel_r   <= cfg_select;
            lock_r  <= cfg_lock;
            addr_r  <= bus_address_field;
            phase_r <= cfg_spi_phase;
        end
    end

    // two-stage synchronisers, third stage for edges
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sy1_r <= 4'hf;
            sy2_r <= 4'hf;
            sy3_r <= 4'hf;
        end else begin
            sy1_r <= {scl_in, sda_in, sclk_in, ss_n_in};
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
        end
    end

    assign {scl_s, sda_s, sclk_s, ss_s} = sy2_r;
    assign i2c_on    = uses_i2c(sel_r);
    assign spi_on    = sel_r == srsp_pkg::SEL_SPI;
    assign scl_rise  = scl_s & ~sy3_r[3];
    assign scl_fall  = ~scl_s & sy3_r[3];
    assign i2c_start = i2c_on & scl_s & sy3_r[3] & ~sda_s & sy3_r[2];
    assign i2c_stop  = i2c_on & scl_s & sy3_r[3] & sda_s & ~sy3_r[2];
    assign sclk_rise = sclk_s & ~sy3_r[1];
    assign sclk_fall = ~sclk_s & sy3_r[1];
    assign ss_fall   = spi_on & ~ss_s & sy3_r[0];
    assign ss_rise   = spi_on & ss_s & ~sy3_r[0];
    assign busy      = (st_r != srsp_pkg::I_IDLE) | (spi_on & ~ss_s);
    assign f_pop     = f_valid & ~busy;
    assign rd_start  = ss_fall | (st_r == srsp_pkg::I_ADDR && scl_fall
                       && bit_r == srsp_pkg::BYTE_BITS && rx_r[0]
                       && (lock_r != srsp_pkg::LOCK_ON || rx_r[7:1] == addr_r));

    // packet: status, capacitance, temperature, msb first
    always_comb begin
        packet[31:30] = command_mode ? srsp_pkg::STAT_CMD
                      : (fresh_r ? srsp_pkg::STAT_FRESH : srsp_pkg::STAT_STALE);
        packet[29:16] = diag_r ? srsp_pkg::DIAG_VAL : cap_r;
        packet[15:2]  = diag_r ? srsp_pkg::DIAG_VAL : temp_r;
        packet[1:0]   = 2'h0;
    end

    // output register refreshed only between transfers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            diag_r <= 1'b0;
            cap_r  <= '0;
            temp_r <= '0;
        end else if (f_pop) begin
            {diag_r, cap_r, temp_r} <= f_data;
        end
    end

    // new data flag drives status and ready; a new result wins over a read
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fresh_r <= 1'b0;
        end else if (f_pop) begin
            fresh_r <= 1'b1;
        end else if (rd_start) begin
            fresh_r <= 1'b0;
        end
    end

    // i2c slave state machine
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r     <= srsp_pkg::I_IDLE;
            bit_r    <= '0;
            rx_r     <= '0;
            rw_r     <= 1'b0;
            acked_r  <= 1'b0;
            tx_r     <= '0;
        end else if (!i2c_on || i2c_stop) begin
            st_r <= srsp_pkg::I_IDLE;
        end else if (i2c_start) begin
            st_r  <= srsp_pkg::I_ADDR;
            bit_r <= '0;
        end else begin
            case (st_r)
                srsp_pkg::I_ADDR, srsp_pkg::I_RX: begin
                    if (scl_rise) begin
                        rx_r  <= {rx_r[6:0], sda_s};
                        bit_r <= bit_r + 1'b1;
                    end else if (scl_fall && bit_r == srsp_pkg::BYTE_BITS) begin
                        bit_r <= '0;
                        if (st_r == srsp_pkg::I_RX) begin
                            st_r <= srsp_pkg::I_ACKW;
                        end else if (lock_r != srsp_pkg::LOCK_ON
                                     || rx_r[7:1] == addr_r) begin
                            st_r <= srsp_pkg::I_ACKA;
                            rw_r <= rx_r[0];
                            if (rx_r[0]) begin
                                tx_r <= packet;
                            end
                        end else begin
                            st_r <= srsp_pkg::I_IDLE;
                        end
                    end
                end
                srsp_pkg::I_ACKA: begin
                    if (scl_fall) begin
                        st_r <= rw_r ? srsp_pkg::I_TX : srsp_pkg::I_RX;
                    end
                end
                srsp_pkg::I_ACKW: begin
                    if (scl_fall) begin
                        st_r <= srsp_pkg::I_RX;
                    end
                end
                srsp_pkg::I_TX: begin
                    if (scl_rise) begin
                        bit_r <= bit_r + 1'b1;
                    end else if (scl_fall) begin
                        if (bit_r == srsp_pkg::BYTE_BITS) begin
                            st_r  <= srsp_pkg::I_MACK;
                            bit_r <= '0;
                        end else begin
                            tx_r <= {tx_r[30:0], tx_r[31]};
                        end
                    end
                end
                srsp_pkg::I_MACK: begin
                    if (scl_rise) begin
                        acked_r <= ~sda_s;
                    end else if (scl_fall) begin
                        // packet wraps so bytes keep coming until nack
                        st_r <= acked_r ? srsp_pkg::I_TX : srsp_pkg::I_IDLE;
                        tx_r <= {tx_r[30:0], tx_r[31]};
                    end
                end
                default: begin
                    st_r <= srsp_pkg::I_IDLE;
                end
            endcase
        end
    end

    // open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe  = (st_r == srsp_pkg::I_ACKA) || (st_r == srsp_pkg::I_ACKW)
                     || (st_r == srsp_pkg::I_TX && !tx_r[31]);

    // event pulses and calibration bytes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            conversion_request_command <= 1'b0;
            result_read_command        <= 1'b0;
            cmd_valid                  <= 1'b0;
            cmd_byte                   <= '0;
            rd_i2c_r                   <= 1'b0;
        end else begin
            conversion_request_command <= st_r == srsp_pkg::I_ACKA && !rw_r
                                          && scl_fall;
            cmd_valid <= command_mode && st_r == srsp_pkg::I_RX && scl_fall
                         && bit_r == srsp_pkg::BYTE_BITS;
            if (st_r == srsp_pkg::I_RX && scl_fall && bit_r == srsp_pkg::BYTE_BITS) begin
                cmd_byte <= rx_r;
            end
            if (st_r == srsp_pkg::I_ACKA) begin
                rd_i2c_r <= rw_r;
            end else if (st_r == srsp_pkg::I_IDLE) begin
                rd_i2c_r <= 1'b0;
            end
            result_read_command <= ss_rise
                                   | (rd_i2c_r & st_r == srsp_pkg::I_IDLE);
        end
    end

    // spi transmitter, 32-bit packet, drives nothing it receives
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            spi_r    <= '0;
            seen_r   <= 1'b0;
            miso_out <= 1'b0;
            miso_oe  <= 1'b0;
        end else begin
            miso_oe <= spi_on & ~ss_s;
            if (ss_fall) begin
                spi_r  <= packet;
                seen_r <= 1'b0;
            end else if (spi_on && !ss_s) begin
                // sampling edge first, then shift on the opposite edge
                if (phase_r ? sclk_fall : sclk_rise) begin
                    seen_r <= 1'b1;
                end else if ((phase_r ? sclk_rise : sclk_fall) && seen_r) begin
                    spi_r <= {spi_r[30:0], 1'b0};
                end
            end
            miso_out <= ss_fall ? packet[31] : spi_r[31];
        end
    end

    // shared pin routing
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_alarm_low_out  <= 1'b0;
            pin_alarm_high_out <= 1'b0;
            pin_ready_out      <= 1'b0;
        end else begin
            pin_alarm_low_out  <= (sel_r == srsp_pkg::SEL_PDM_CT)
                                  ? temperature_density_out : alarm_low;
            pin_alarm_high_out <= alarm_high;
            pin_ready_out      <= (sel_r == srsp_pkg::SEL_CAPACITANCE_DENSITY_OUT
                                   || sel_r == srsp_pkg::SEL_PDM_CT)
                                  ? capacitance_density_out : fresh_r;
        end
    end

    sequence s_sample_edge;
        seen_r && !ss_s;
    endsequence

    chk_miso_float: assert property (@(posedge clk) disable iff (!nrst)
        $rose(ss_s) |=> !miso_oe) else $error("miso driven after deselect");
    chk_sda_idle: assert property (@(posedge clk) disable iff (!nrst)
        (st_r == srsp_pkg::I_IDLE) |-> !sda_oe) else $error("sda driven while idle");
    chk_addr_lock: assert property (@(posedge clk) disable iff (!nrst)
        (st_r == srsp_pkg::I_ADDR && scl_fall && bit_r == srsp_pkg::BYTE_BITS
         && lock_r == srsp_pkg::LOCK_ON && rx_r[7:1] != addr_r && !i2c_stop)
        |=> st_r == srsp_pkg::I_IDLE) else $error("locked address not filtered");
    chk_ready_hold: assert property (@(posedge clk) disable iff (!nrst)
        (fresh_r && !rd_start) |=> fresh_r) else $error("ready dropped without read");
    chk_ready_pin: assert property (@(posedge clk) disable iff (!nrst)
        (sel_r == srsp_pkg::SEL_I2C) ##1 (sel_r == srsp_pkg::SEL_I2C)
        |-> pin_ready_out == $past(fresh_r)) else $error("ready pin mismatch");
    chk_temp_density: assert property (@(posedge clk) disable iff (!nrst)
        $past(sel_r) == srsp_pkg::SEL_PDM_CT |-> pin_alarm_low_out
        == $past(temperature_density_out)) else $error("temperature density missing");
    chk_snap_load: assert property (@(posedge clk) disable iff (!nrst)
        ss_fall |=> spi_r == $past(packet)) else $error("spi snapshot wrong");
    chk_diag_sat: assert property (@(posedge clk) disable iff (!nrst)
        diag_r |-> packet[29:2] == {srsp_pkg::DIAG_VAL, srsp_pkg::DIAG_VAL})
        else $error("diagnostic not saturated");
    chk_no_early_shift: assert property (@(posedge clk) disable iff (!nrst)
        $fell(ss_s) ##1 (!seen_r && !ss_s) [*2] |-> spi_r == $past(spi_r))
        else $error("shift before first sample edge");
    chk_shift_phase: assert property (@(posedge clk) disable iff (!nrst)
        s_sample_edge ##0 (!phase_r && sclk_fall && spi_on) |=> spi_r == {$past(spi_r[30:0]),
        1'b0}) else $error("spi shift on wrong edge");
endmodule : srsp_port

// ===== dv/srsp_host.sv
// srsp_host: behavioural i2c and spi master facing the result port
// assumes the bench resolves sda and miso; pins change at falling clk
`timescale 1ns/1ns
module srsp_host (
    input  wire logic  clk,
    input  wire logic  sda,
    input  wire logic  miso,
    output logic       scl,
    output logic       sda_lo,
    output logic       sclk,
    output logic       ss_n,
    output logic       rx_stb,
    output logic [7:0] rx_byte,
    output logic       acked
);
    int hi = 25;
    initial begin
        {scl, sda_lo, sclk, ss_n, rx_stb, acked} = 6'h24;
        rx_byte = 8'h00;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask : w
    task automatic emit(input logic [7:0] d);
        rx_byte = d;
        rx_stb = 1'b1;
        w(1);
        rx_stb = 1'b0;
    endtask : emit
    task automatic hold(input logic v);
        ss_n = v;
        w(1);
    endtask : hold
    // data set while scl low, sampled at the end of the high phase
    task automatic bit_io(input logic b, output logic r);
        sda_lo = ~b;
        w(hi);
        scl = 1'b1;
        w(hi);
        r = sda;
        scl = 1'b0;
        w(1);
    endtask : bit_io
    task automatic i2c(input logic [6:0] a, input logic rw, input int n,
                       input logic [7:0] wd);
        logic [7:0] d;
        logic       r;
        d = {a, rw};
        w(hi);
        sda_lo = 1'b1;
        w(hi);
        scl = 1'b0;
        w(1);
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        acked = ~r;
        for (int j = 0; j < n && acked; j++) begin
            for (int i = 7; i >= 0; i--) begin
                bit_io(rw | wd[i], r);
                d[i] = r;
            end
            if (rw) emit(d);
            bit_io(~rw | (j == n - 1), r);
        end
        sda_lo = 1'b1;
        w(hi);
        scl = 1'b1;
        w(hi);
        sda_lo = 1'b0;
        w(30);
    endtask : i2c
    // read only: nothing is sent towards the port
    task automatic spi(input logic ph, input logic idle, input int n);
        logic [7:0] d;
        d = 8'h00;
        sclk = idle;
        w(2);
        ss_n = 1'b0;
        w(50);
        for (int i = 0; i < n; i++) begin
            for (int e = 0; e < 2; e++) begin
                sclk = idle ^ (e == 0);
                if (sclk == ~ph) d = {d[6:0], miso};
                w(13);
            end
            if (i % 8 == 7) emit(d);
        end
        ss_n = 1'b1;
        w(40);
    endtask : spi
endmodule : srsp_host

// ===== dv/srsp_port_tb.sv
// srsp_port_tb: self-checking bench for the result serial port
// assumes srsp_host plays the master; sda has a pull-up here
`timescale 1ns/1ns
module srsp_port_tb;
    logic        clk = 1'b0;
    logic        nrst, cfg_write, phase, cmd_mode, res_valid, res_diag, res_ready;
    logic        al, ah, cd, td, pin_lo, pin_hi, pin_rdy, sda_out, sda_oe;
    logic        miso_out, miso_oe, conv, rd_done, cmd_valid, miso_x = 1'b0;
    logic        scl, sda_lo, sclk, ss_n, rx_stb, acked;
    logic [2:0]  sel, lock;
    logic [2:0]  sel_tab [4] = '{3'h1, 3'h3, 3'h4, 3'h6};
    logic [6:0]  addr, a_rnd;
    logic [7:0]  cmd_byte, rx_byte, last_cmd;
    logic [13:0] cap, temp, c, t;
    logic [15:0] e;
    logic [15:0] expq [$];
    int          seed, checks = 0, n_mismatch = 0, n_conv = 0, n_rd = 0, k;
    wire         sda  = ~((sda_oe & ~sda_out) | sda_lo);
    wire         miso = miso_oe ? miso_out : miso_x;
    srsp_port u_srsp_port (
        .clk(clk), .nrst(nrst), .cfg_write(cfg_write), .cfg_select(sel), .cfg_lock(lock),
        .bus_address_field(addr), .cfg_spi_phase(phase), .command_mode(cmd_mode),
        .res_valid(res_valid), .res_ready(res_ready), .res_diag(res_diag), .res_cap(cap),
        .res_temp(temp), .alarm_low(al), .alarm_high(ah), .capacitance_density_out(cd),
        .temperature_density_out(td), .pin_alarm_low_out(pin_lo),
        .pin_alarm_high_out(pin_hi), .pin_ready_out(pin_rdy), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .sclk_in(sclk), .ss_n_in(ss_n),
        .miso_out(miso_out), .miso_oe(miso_oe), .conversion_request_command(conv),
        .result_read_command(rd_done), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid)
    );
    srsp_host u_host (
        .clk(clk), .sda(sda), .miso(miso), .scl(scl), .sda_lo(sda_lo), .sclk(sclk),
        .ss_n(ss_n), .rx_stb(rx_stb), .rx_byte(rx_byte), .acked(acked)
    );
    always #25 clk = ~clk;
    // monitor: pulse counters and received bytes against the oldest note
    always @(posedge clk) begin
        miso_x <= ~miso_x;
        n_conv <= n_conv + int'(conv === 1'b1);
        n_rd <= n_rd + int'(rd_done === 1'b1);
        if (cmd_valid === 1'b1) last_cmd <= cmd_byte;
        if (rx_stb === 1'b1) begin
            e = expq.pop_front();
            chk(16'(rx_byte & e[15:8]), 16'(e[7:0]));
        end
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        checks++;
        if (g !== x) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk
    task automatic cfg(input logic [2:0] s, input logic [2:0] l, input logic p);
        @(negedge clk);
        {sel, lock, phase, cfg_write} = {s, l, p, 1'b1};
        @(negedge clk);
        cfg_write = 1'b0;
    endtask : cfg
    task automatic push(input logic dg, input logic [13:0] cv, input logic [13:0] tv);
        @(negedge clk);
        {res_valid, res_diag, cap, temp} = {1'b1, dg, cv, tv};
        while (res_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        res_valid = 1'b0;
    endtask : push
    task automatic exp_pkt(input logic [1:0] st, input logic [13:0] cv,
                           input logic [13:0] tv, input int n);
        logic [31:0] p;
        p = {st, cv, tv, 2'b00};
        for (int i = 0; i < n; i++) expq.push_back({(i == 3) ? 8'hfc : 8'hff, p[31-8*i -: 8]});
    endtask : exp_pkt
    task automatic rd(input logic [6:0] a, input logic ak, input int n);
        u_host.i2c(a, 1'b1, n, 8'h00);
        chk(16'(acked), 16'(ak));
    endtask : rd
    task automatic finish_test;
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end
    initial begin
        seed = 3569;
        {nrst, cfg_write, phase, cmd_mode, res_valid, res_diag, al, ah, cd, td} = 10'h0;
        {sel, lock, addr, cap, temp} = {3'h1, 3'h3, 7'h28, 28'h0};
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        chk(16'({res_ready, sda_oe, miso_oe, pin_rdy, conv, rd_done}), 16'h20);
        c = 14'($random(seed));
        t = 14'($random(seed));
        push(1'b0, ~c, ~t);
        push(1'b0, c, t);
        repeat (6) @(negedge clk);
        chk(16'(pin_rdy), 16'h1);
        exp_pkt(2'h0, c, t, 4);
        rd(7'h28, 1'b1, 4);
        chk(16'(pin_rdy), 16'h0);
        u_host.hi = 100;
        exp_pkt(2'h1, c, t, 2);
        rd(7'h28, 1'b1, 2);
        u_host.hi = 25;
        rd(7'h29, 1'b0, 1);
        cfg(srsp_pkg::SEL_I2C, 3'h2, 1'b0);
        a_rnd = 7'($random(seed));
        exp_pkt(2'h1, c, t, 1);
        rd(a_rnd, 1'b1, 1);
        u_host.i2c(a_rnd, 1'b0, 0, 8'h00);
        chk(16'(n_conv), 16'h1);
        cmd_mode = 1'b1;
        u_host.i2c(7'h28, 1'b0, 1, c[7:0]);
        chk(16'(last_cmd), 16'(c[7:0]));
        exp_pkt(2'h2, c, t, 1);
        rd(7'h28, 1'b1, 1);
        cmd_mode = 1'b0;
        push(1'b1, c, t);
        repeat (6) @(negedge clk);
        exp_pkt(2'h0, srsp_pkg::DIAG_VAL, srsp_pkg::DIAG_VAL, 4);
        rd(7'h5a, 1'b1, 4);
        cfg(srsp_pkg::SEL_SPI, srsp_pkg::LOCK_ON, 1'b0);
        chk(16'(miso_oe), 16'h0);
        rd(7'h28, 1'b0, 1);
        push(1'b0, t, c);
        repeat (6) @(negedge clk);
        k = n_rd;
        exp_pkt(2'h0, t, c, 4);
        u_host.spi(1'b0, 1'b0, 32);
        cfg(srsp_pkg::SEL_SPI, srsp_pkg::LOCK_ON, 1'b1);
        exp_pkt(2'h1, t, c, 2);
        u_host.spi(1'b1, 1'b1, 16);
        chk(16'(n_rd - k), 16'h2);
        u_host.hold(1'b0);
        repeat (6) @(negedge clk);
        for (int i = 0; i < 16; i++) push(1'b0, 14'(i), ~14'(i));
        chk(16'(res_ready), 16'h0);
        u_host.hold(1'b1);
        repeat (80) @(negedge clk);
        chk(16'(res_ready), 16'h1);
        exp_pkt(2'h0, 14'h000f, ~14'h000f, 4);
        u_host.spi(1'b1, 1'b0, 32);
        for (int i = 0; i < 8; i++) begin
            cfg(sel_tab[i%4], srsp_pkg::LOCK_ON, 1'b0);
            {al, ah, cd, td} = 4'($random(seed));
            repeat (3) @(negedge clk);
            chk(16'({pin_lo, pin_hi, pin_rdy}),
                16'({sel_tab[i%4] == 3'h6 ? td : al, ah, sel_tab[i%4][2] & cd}));
        end
        chk(16'(expq.size()), 16'h0);
        finish_test();
    end
endmodule : srsp_port_tb
